// ---- hw/txmod_pkg.sv ----
// constants shared by the modulator end and the bench
package txmod_pkg;
  // chip operating mode codes
  localparam logic [2:0] MODE_TX = 3'h4;
  localparam logic [2:0] MODE_RX = 3'h3;
  // divider field widths and reset values
  localparam int BR_DIV_W = 8;
  localparam int DEV_DIV_W = 8;
  localparam logic [7:0] BR_DIV_RESET = 8'h07;
  // 12.8 MHz / (32 * (1 + 3)) = 100 kHz default deviation
  localparam logic [7:0] DEV_DIV_RESET = 8'h03;
  localparam int BR_PRESCALE = 64;
  localparam int DEV_PRESCALE = 32;
  // dds phase: 16 steps per deviation period, so 2*(1+n) clocks per step
  localparam int DDS_STEPS = 16;
  localparam int PHASE_W = 4;
  localparam logic [3:0] QUARTER = 4'h4;
  // pa ramp times in nanoseconds, selected by a two-bit code
  localparam int CLK_PERIOD_NS = 20;
  localparam int RAMP0_NS = 3000;
  localparam int RAMP1_NS = 8500;
  localparam int RAMP2_NS = 15000;
  localparam int RAMP3_NS = 23000;
  localparam int RAMP_CNT_W = 11;
  // slew times rounded up to whole clock cycles
  localparam logic [10:0] RAMP0_CYC =
    11'((RAMP0_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS);
  localparam logic [10:0] RAMP1_CYC =
    11'((RAMP1_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS);
  localparam logic [10:0] RAMP2_CYC =
    11'((RAMP2_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS);
  localparam logic [10:0] RAMP3_CYC =
    11'((RAMP3_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS);
endpackage

// ---- hw/txmod_if.sv ----
// link between the modulator and the companion data source
`timescale 1ns/1ps
interface txmod_if;
  logic data_clock_out; // bit clock from the modulator
  logic tx_data; // transmit bit from the companion
  modport modulator (output data_clock_out, input tx_data);
  modport source (input data_clock_out, output tx_data);
endinterface

// ---- hw/tx_data_source.sv ----
// companion end: buffers user bits and presents one per bit clock
`timescale 1ns/1ps
module tx_data_source (
  input wire logic CLK_I, // system clock
  input wire logic RESET_I, // async reset, high
  txmod_if.source LINK, // link to modulator
  input wire logic BIT_VALID_I, // user bit offered
  input wire logic BIT_I, // user bit
  output logic BIT_READY_O, // buffer has room
  output logic UNDERRUN_O // bit clock found buffer empty
);
  // ----------------------------------------
  // link clock sampling
  // ----------------------------------------
  logic data_clock_out_s1, data_clock_out_s2, data_clock_out_d;
  always_ff @(posedge CLK_I or posedge RESET_I) begin
    if (RESET_I) begin
      data_clock_out_s1 <= 1'b0;
      data_clock_out_s2 <= 1'b0;
      data_clock_out_d <= 1'b0;
    end else begin
      data_clock_out_s1 <= LINK.data_clock_out;
      data_clock_out_s2 <= data_clock_out_s1;
      data_clock_out_d <= data_clock_out_s2;
    end
  end
  wire logic data_clock_out_rise = data_clock_out_s2 & ~data_clock_out_d;
  // ----------------------------------------
  // two-entry buffer
  // ----------------------------------------
  logic [1:0] mem;
  logic wr_ptr, rd_ptr;
  logic [1:0] count;
  wire logic push = BIT_VALID_I & BIT_READY_O;
  wire logic pop = data_clock_out_rise & (count != 2'h0);
  assign BIT_READY_O = (count != 2'h2);
  always_ff @(posedge CLK_I or posedge RESET_I) begin
    if (RESET_I) begin
      mem <= 2'h0;
      wr_ptr <= 1'b0;
      rd_ptr <= 1'b0;
      count <= 2'h0;
    end else begin
      if (push) mem[wr_ptr] <= BIT_I;
      if (push) wr_ptr <= ~wr_ptr;
      if (pop) rd_ptr <= ~rd_ptr;
      count <= count + {1'b0, push} - {1'b0, pop};
    end
  end
  // next bit presented on each bit clock rising edge
  always_ff @(posedge CLK_I or posedge RESET_I) begin
    if (RESET_I) begin
      LINK.tx_data <= 1'b0;
      UNDERRUN_O <= 1'b0;
    end else begin
      UNDERRUN_O <= data_clock_out_rise & (count == 2'h0);
      if (pop) LINK.tx_data <= mem[rd_ptr]; // R7
    end
  end
endmodule // tx_data_source

// ---- hw/tx_modulator.sv ----
// device end: baseband dds, fsk/ook keying, pa control and bit clock
`timescale 1ns/1ps
// Function
// R1: fsk flips i/q phase -90/+90, continuous
// R2: data one gives plus deviation, zero minus
// R3: i/q oscillate at programmed deviation frequency
// R4: ook holds i/q phase offset constant
// R5: ook gates pa and regulator by data
// R6: bit rate is xtal/(64*(1+divider))
// R7: bit clock pulses; companion supplies next bit
// R8: deviation is xtal/(32*(1+divider))
// R9: software keeps modulation index at least two
// R10: software keeps deviation at least 33 kHz
// R11: deviation divider defaults to 100 kHz
// R12: software sets interpolation bandwidth near 3x
// R13: ook ramp code selects regulator slew time
// R14: transmit mode keeps pa and regulator on
// R15: receive mode turns pa off, regulator grounded
// R16: mode code 100 enters transmit
// R17: mode code 011 enters receive
// R18: data changes take effect only at bit boundaries
module tx_modulator #(
  parameter int BR_W = txmod_pkg::BR_DIV_W, // bit rate divider width
  parameter int DEV_W = txmod_pkg::DEV_DIV_W // deviation divider width
) (
  input wire logic CLK_I, // crystal clock, 50 MHz in bench
  input wire logic RESET_I, // async reset, high
  txmod_if.modulator LINK, // link to companion
  input wire logic [2:0] CHIP_OPERATING_MODE_I, // chip mode field
  input wire logic OOK_MODE_I, // 1 ook, 0 fsk
  input wire logic [BR_W-1:0] BIT_RATE_DIVIDER_I, // bit rate divider
  input wire logic [DEV_W-1:0] DEVIATION_DIVIDER_I, // deviation divider
  input wire logic DEV_DEFAULT_I, // use reset deviation setting
  input wire logic [1:0] PA_RAMP_SELECT_I, // ook ramp code
  input wire logic [7:0] TX_INTERP_FILTER_BW_I, // filter bw code
  output logic [7:0] INTERP_BW_O, // filter bw applied
  output logic [3:0] I_PHASE_O, // i channel dds phase
  output logic [3:0] Q_PHASE_O, // q channel dds phase
  output logic PA_ON_O, // power amplifier enable
  output logic PA_REG_ON_O, // regulator enable
  output logic PA_REG_GROUND_O, // regulator output tied low
  output logic [10:0] PA_RAMP_CYCLES_O, // slew time in cycles
  output logic TX_ACTIVE_O // transmit mode active
);
  // ----------------------------------------
  // mode decode
  // ----------------------------------------
  wire logic tx_mode = (CHIP_OPERATING_MODE_I == txmod_pkg::MODE_TX); // R16
  wire logic rx_mode = (CHIP_OPERATING_MODE_I == txmod_pkg::MODE_RX); // R17
  wire logic [DEV_W-1:0] dev_div = DEV_DEFAULT_I ?
    DEV_W'(txmod_pkg::DEV_DIV_RESET) : DEVIATION_DIVIDER_I; // R11

  // ----------------------------------------
  // bit rate divider: 64*(1+n) clocks per bit
  // ----------------------------------------
  localparam int BRC_W = BR_W + 6;
  logic [BRC_W-1:0] br_cnt;
  // last count of a bit period; widened so 64*(1+n)-1 always fits
  wire logic [BRC_W-1:0] br_last = BRC_W'(
    (BRC_W'(BIT_RATE_DIVIDER_I) + BRC_W'(1)) *
    BRC_W'(txmod_pkg::BR_PRESCALE) - 1);
  wire logic bit_tick = tx_mode & (br_cnt >= br_last);
  always_ff @(posedge CLK_I or posedge RESET_I) begin
    if (RESET_I) br_cnt <= '0;
    else if (!tx_mode || bit_tick) br_cnt <= '0; // R6
    else br_cnt <= br_cnt + BRC_W'(1);
  end

  // bit clock high in first half of each bit period
  // rising edge follows the bit boundary, giving the companion
  // the whole high half to present its next bit
  always_ff @(posedge CLK_I or posedge RESET_I) begin
    if (RESET_I) LINK.data_clock_out <= 1'b0;
    else LINK.data_clock_out <= tx_mode & (br_cnt < (br_last >> 1)); // R7
  end

  // ----------------------------------------
  // two-entry input buffer for data bits
  // ----------------------------------------
  logic data_s1, data_s2;
  logic data_clock_out_prev;
  logic [1:0] buf_mem;
  logic buf_wr, buf_rd;
  logic [1:0] buf_cnt;
  // bits sampled mid-bit, on the falling edge of the bit clock
  wire logic fall = data_clock_out_prev & ~LINK.data_clock_out;
  wire logic in_valid = fall;
  wire logic in_ready = (buf_cnt != 2'h2);
  wire logic out_valid = (buf_cnt != 2'h0);
  wire logic out_ready = bit_tick;
  wire logic push = in_valid & in_ready;
  wire logic pop = out_valid & out_ready;
  always_ff @(posedge CLK_I or posedge RESET_I) begin
    if (RESET_I) begin
      data_s1 <= 1'b0;
      data_s2 <= 1'b0;
      data_clock_out_prev <= 1'b0;
    end else begin
      data_s1 <= LINK.tx_data;
      data_s2 <= data_s1;
      data_clock_out_prev <= LINK.data_clock_out;
    end
  end
  always_ff @(posedge CLK_I or posedge RESET_I) begin
    if (RESET_I) begin
      buf_mem <= 2'h0;
      buf_wr <= 1'b0;
      buf_rd <= 1'b0;
      buf_cnt <= 2'h0;
    end else if (!tx_mode) begin
      buf_wr <= 1'b0;
      buf_rd <= 1'b0;
      buf_cnt <= 2'h0;
    end else begin
      if (push) buf_mem[buf_wr] <= data_s2;
      if (push) buf_wr <= ~buf_wr;
      if (pop) buf_rd <= ~buf_rd;
      buf_cnt <= buf_cnt + {1'b0, push} - {1'b0, pop};
    end
  end

  // symbol register changes only at bit boundaries
  // an empty buffer at a boundary repeats the last symbol
  logic symbol;
  always_ff @(posedge CLK_I or posedge RESET_I) begin
    if (RESET_I) symbol <= 1'b0;
    else if (pop) symbol <= buf_mem[buf_rd]; // R18
  end

  // ----------------------------------------
  // dds: 16 phase steps per deviation period
  // ----------------------------------------
  // step every 2*(1+n) clocks, so period = 32*(1+n) clocks
  localparam int DVC_W = DEV_W + 2;
  logic [DVC_W-1:0] dv_cnt;
  logic [3:0] phase;
  wire logic [DVC_W-1:0] dv_last = DVC_W'(
    (DVC_W'(dev_div) + DVC_W'(1)) *
    DVC_W'(txmod_pkg::DEV_PRESCALE / txmod_pkg::DDS_STEPS) - 1);
  wire logic dds_step = (dv_cnt >= dv_last);
  always_ff @(posedge CLK_I or posedge RESET_I) begin
    if (RESET_I) begin
      dv_cnt <= '0;
      phase <= 4'h0;
    end else if (dds_step) begin
      dv_cnt <= '0;
      phase <= phase + 4'h1; // R3 R8
    end else begin
      dv_cnt <= dv_cnt + DVC_W'(1);
    end
  end

  // ----------------------------------------
  // i/q phase: q leads (+90) for one and in ook, lags (-90) for fsk zero
  // ----------------------------------------
  // accumulator runs freely, so only the q offset flips: no phase jump on i
  wire logic lead = OOK_MODE_I ? 1'b1 : symbol; // R1 R2 R4
  wire logic [3:0] q_phase = lead ? phase + txmod_pkg::QUARTER
                                  : phase - txmod_pkg::QUARTER;
  always_ff @(posedge CLK_I or posedge RESET_I) begin
    if (RESET_I) begin
      I_PHASE_O <= 4'h0;
      Q_PHASE_O <= 4'h0;
    end else begin
      I_PHASE_O <= phase; // R3
      Q_PHASE_O <= q_phase; // R1
    end
  end

  // ----------------------------------------
  // pa control
  // ----------------------------------------
  // pa and regulator follow the symbol, so ook keying lands on
  // bit boundaries; any mode other than tx leaves the pa grounded
  wire logic pa_want = tx_mode & (~OOK_MODE_I | symbol); // R5 R14
  wire logic [10:0] ramp_cyc =
    (PA_RAMP_SELECT_I == 2'h0) ? txmod_pkg::RAMP0_CYC :
    (PA_RAMP_SELECT_I == 2'h1) ? txmod_pkg::RAMP1_CYC :
    (PA_RAMP_SELECT_I == 2'h2) ? txmod_pkg::RAMP2_CYC :
                                 txmod_pkg::RAMP3_CYC; // R13
  always_ff @(posedge CLK_I or posedge RESET_I) begin
    if (RESET_I) begin
      PA_ON_O <= 1'b0;
      PA_REG_ON_O <= 1'b0;
      PA_REG_GROUND_O <= 1'b1;
      PA_RAMP_CYCLES_O <= txmod_pkg::RAMP0_CYC;
      TX_ACTIVE_O <= 1'b0;
      INTERP_BW_O <= 8'h00;
    end else begin
      PA_ON_O <= pa_want & ~rx_mode; // R15
      PA_REG_ON_O <= pa_want & ~rx_mode; // R5 R14
      PA_REG_GROUND_O <= ~pa_want | rx_mode; // R15
      PA_RAMP_CYCLES_O <= ramp_cyc; // R13
      TX_ACTIVE_O <= tx_mode;
      INTERP_BW_O <= TX_INTERP_FILTER_BW_I; // R12
    end
  end
endmodule // tx_modulator

// ---- bench/tx_baseband_modulator_properties.sv ----
// concurrent checks on the link and the modulator outputs
`timescale 1ns/1ps
module tx_baseband_modulator_properties (
  input wire logic CLK_I, // clock
  input wire logic RESET_I, // async reset
  input wire logic data_clock_out, // bit clock
  input wire logic tx_data, // link bit
  input wire logic [2:0] CHIP_OPERATING_MODE_I, // mode field
  input wire logic OOK_MODE_I, // ook select
  input wire logic [7:0] BIT_RATE_DIVIDER_I, // bit rate divider
  input wire logic DEV_DEFAULT_I, // default deviation
  input wire logic [1:0] PA_RAMP_SELECT_I, // ramp code
  input wire logic [3:0] I_PHASE_O, // i phase
  input wire logic [3:0] Q_PHASE_O, // q phase
  input wire logic PA_ON_O, // pa enable
  input wire logic PA_REG_ON_O, // regulator enable
  input wire logic PA_REG_GROUND_O, // regulator grounded
  input wire logic [10:0] PA_RAMP_CYCLES_O, // slew cycles
  input wire logic TX_ACTIVE_O // tx mode
);
  logic [15:0] cnt;
  logic seen;
  // ----------------------------------------
  // bit period counter
  // ----------------------------------------
  always_ff @(posedge CLK_I or posedge RESET_I) begin
    if (RESET_I) begin
      cnt <= 16'h0000;
      seen <= 1'b0;
    end else begin
      cnt <= $rose(data_clock_out) ? 16'h0001 : cnt + 16'h0001;
      seen <= TX_ACTIVE_O && (seen || $rose(data_clock_out));
    end
  end
  // expected slew cycles per ramp code
  function automatic logic [10:0] ramp(input logic [1:0] c);
    case (c)
      2'h0: return txmod_pkg::RAMP0_CYC;
      2'h1: return txmod_pkg::RAMP1_CYC;
      2'h2: return txmod_pkg::RAMP2_CYC;
      default: return txmod_pkg::RAMP3_CYC;
    endcase
  endfunction
  default clocking cb @(posedge CLK_I); endclocking
  default disable iff (RESET_I);
  chk_tx_mode_entry: assert property (
    CHIP_OPERATING_MODE_I == txmod_pkg::MODE_TX |=> TX_ACTIVE_O)
    else $error("tx mode not entered");
  chk_rx_pa_off: assert property (
    (CHIP_OPERATING_MODE_I == txmod_pkg::MODE_RX) [*2]
    |-> !PA_ON_O && !PA_REG_ON_O && PA_REG_GROUND_O)
    else $error("pa not off in rx");
  chk_tx_pa_on: assert property (
    (TX_ACTIVE_O && !OOK_MODE_I) [*2]
    |-> PA_ON_O && PA_REG_ON_O && !PA_REG_GROUND_O)
    else $error("pa not on in fsk tx");
  chk_clock_idle: assert property (
    !TX_ACTIVE_O [*2] |-> !data_clock_out)
    else $error("bit clock runs outside tx");
  chk_bit_period: assert property (
    $rose(data_clock_out) && seen
    |-> cnt == 16'(64 * (BIT_RATE_DIVIDER_I + 8'h01)))
    else $error("bit period wrong");
  chk_link_data: assert property (
    TX_ACTIVE_O && $changed(tx_data) |-> data_clock_out)
    else $error("link bit changed late");
  chk_ook_phase: assert property (
    (TX_ACTIVE_O && OOK_MODE_I) [*3] ##0 $stable(I_PHASE_O)
    |-> Q_PHASE_O == 4'(I_PHASE_O + txmod_pkg::QUARTER))
    else $error("ook phase offset not fixed");
  chk_dds_step: assert property (
    TX_ACTIVE_O && DEV_DEFAULT_I && $changed(I_PHASE_O)
    |=> ($stable(I_PHASE_O) || !TX_ACTIVE_O) [*7]
    ##1 ($changed(I_PHASE_O) || !TX_ACTIVE_O))
    else $error("dds step rate wrong");
  chk_ook_boundary: assert property (
    TX_ACTIVE_O && $past(TX_ACTIVE_O) && OOK_MODE_I
    && $stable(OOK_MODE_I) && $changed(PA_ON_O)
    |-> $rose(data_clock_out))
    else $error("ook keying off boundary");
  chk_ramp_code: assert property (
    OOK_MODE_I |=> PA_RAMP_CYCLES_O == ramp($past(PA_RAMP_SELECT_I)))
    else $error("ramp time wrong");
  cover property ($rose(data_clock_out) && seen);
  cover property (OOK_MODE_I && $rose(PA_ON_O));
  cover property ($rose(PA_REG_GROUND_O));
endmodule // tx_baseband_modulator_properties

// ---- bench/tx_baseband_modulator_tb.sv ----
// self-checking bench: modulator and data source joined by the link
`timescale 1ns/1ps
module tx_baseband_modulator_tb;
  logic CLK_I = 1'b0;
  logic RESET_I = 1'b1;
  logic [2:0] mode = txmod_pkg::MODE_RX;
  logic ook = 1'b0, ddef = 1'b1, feed = 1'b0, bv = 1'b0, bi = 1'b0;
  logic [7:0] br = 8'h00, dv = 8'h00, fbw = 8'h00, ibw;
  logic [1:0] rs = 2'h0;
  logic [3:0] iph, qph;
  logic pa, preg, pgnd, txa, rdy;
  logic [10:0] rcyc;
  int num_errors = 0, n_compared = 0, cyc = 0;
  int ns[4] = '{txmod_pkg::RAMP0_NS, txmod_pkg::RAMP1_NS,
    txmod_pkg::RAMP2_NS, txmod_pkg::RAMP3_NS};
  bit acc, sent[$], obs[$];
  txmod_if link ();
  tx_modulator tx_modulator_inst (.CLK_I(CLK_I), .RESET_I(RESET_I),
    .LINK(link), .CHIP_OPERATING_MODE_I(mode), .OOK_MODE_I(ook),
    .BIT_RATE_DIVIDER_I(br), .DEVIATION_DIVIDER_I(dv),
    .DEV_DEFAULT_I(ddef), .PA_RAMP_SELECT_I(rs),
    .TX_INTERP_FILTER_BW_I(fbw), .INTERP_BW_O(ibw), .I_PHASE_O(iph),
    .Q_PHASE_O(qph), .PA_ON_O(pa), .PA_REG_ON_O(preg),
    .PA_REG_GROUND_O(pgnd), .PA_RAMP_CYCLES_O(rcyc), .TX_ACTIVE_O(txa));
  tx_data_source tx_data_source_inst (.CLK_I(CLK_I), .RESET_I(RESET_I),
    .LINK(link), .BIT_VALID_I(bv), .BIT_I(bi), .BIT_READY_O(rdy),
    .UNDERRUN_O());
  tx_baseband_modulator_properties props (.CLK_I(CLK_I),
    .RESET_I(RESET_I), .data_clock_out(link.data_clock_out),
    .tx_data(link.tx_data), .CHIP_OPERATING_MODE_I(mode),
    .OOK_MODE_I(ook), .BIT_RATE_DIVIDER_I(br), .DEV_DEFAULT_I(ddef),
    .PA_RAMP_SELECT_I(rs), .I_PHASE_O(iph), .Q_PHASE_O(qph),
    .PA_ON_O(pa), .PA_REG_ON_O(preg), .PA_REG_GROUND_O(pgnd),
    .PA_RAMP_CYCLES_O(rcyc), .TX_ACTIVE_O(txa));
  // ----------------------------------------
  // clock, watchdog and bit feeder
  // ----------------------------------------
  always #10 CLK_I = ~CLK_I;
  always @(posedge CLK_I) begin
    cyc++;
    if (cyc == 60000) begin
      num_errors++;
      print_verdict();
    end
  end
  // records taken bits, offers random ones
  always @(posedge CLK_I) begin
    acc = bv && rdy;
    if (acc) sent.push_back(bi);
    #1;
    bv = feed;
    if (acc) bi = 1'($urandom);
  end
  task automatic tick();
    @(posedge CLK_I);
    #1;
  endtask
  task automatic check(input logic [31:0] seen, input logic [31:0] exp);
    n_compared++;
    if (seen !== exp) begin
      num_errors++;
      $display("[ERR] %0t seen %0h expected %0h", $time, seen, exp);
    end
  endtask
  task automatic print_verdict();
    $display("compared %0d, errors %0d", n_compared, num_errors);
    if (num_errors == 0 && n_compared > 0) $display("*** PASS ***");
    else $display("*** FAIL ***");
    $finish;
  endtask
  // sent bits must reappear in order at some short lag
  function automatic bit aligned();
    bit ok;
    for (int d = 0; d < 7; d++) begin
      ok = 1'b1;
      for (int i = 0; i < 16; i++) if (obs[d + i] != sent[i]) ok = 1'b0;
      if (ok) return 1'b1;
    end
    return 1'b0;
  endfunction
  // one transmit session: rx checks, keyed bits, dds step
  task automatic run(input bit k, input logic [7:0] b, input logic [1:0] r);
    int c;
    logic [3:0] p;
    mode = txmod_pkg::MODE_RX;
    ook = k;
    br = b;
    rs = r;
    // keep 2*fdev/br at least two and fdev well above 33 kHz
    ddef = (b != 8'h00) && 1'($urandom);
    dv = 8'($urandom_range(2 * b + 1));
    fbw = 8'($urandom);
    repeat (40) tick();
    check({pa, preg, pgnd}, 3'b001);
    check(ibw, fbw);
    mode = txmod_pkg::MODE_TX;
    sent.delete();
    obs.delete();
    feed = 1'b1;
    repeat (2) tick();
    check(txa, 1'b1);
    if (k) check(rcyc, (ns[r] + 19) / 20);
    repeat (24) begin
      @(posedge link.data_clock_out);
      repeat (20) tick();
      p = qph - iph;
      obs.push_back(k ? pa : !p[3]);
    end
    if (!k) check(pa, 1'b1);
    check(aligned(), 1'b1);
    p = iph;
    c = 0;
    while (iph === p) tick();
    p = iph;
    while (iph === p) begin
      tick();
      c++;
    end
    check(c, 2 * (1 + (ddef ? 3 : dv)));
    feed = 1'b0;
    $display("test done ook %0d br %0d ramp %0d", k, b, r);
  endtask
  initial begin
    void'($urandom(32'h26d1_81f0));
    repeat (16) tick();
    RESET_I = 1'b0;
    run(1'b0, 8'h00, 2'h0);
    run(1'b0, 8'h03, 2'h1);
    for (int r = 0; r < 4; r++) run(1'b1, 8'($urandom_range(3)), 2'(r));
    print_verdict();
  end
endmodule // tx_baseband_modulator_tb
